//--- logic/ascs_pkg.sv
// Constants, command layout and state types of the ADC scan sequencer.
// Assumes a 125 MHz system clock; the serial pins arrive asynchronously.
package ascs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_NS        = 8;
    localparam int T_ACQ_NS      = 1400;
    localparam int ACQ_CYC       = (T_ACQ_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_REF_WAKE_NS = 65000;
    localparam int REF_WAKE_CYC  = (T_REF_WAKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TIMER_W       = 14;

    ////////////////////////////////////////////////////////////////////////
    // Command byte selector bits and field positions
    localparam int CMD_CONV_BIT   = 7;
    localparam int CMD_SETUP_BIT  = 6;
    localparam int CMD_AVG_BIT    = 5;
    localparam int CMD_RESET_BIT  = 4;
    localparam int CONV_CH_LSB    = 3;
    localparam int CONV_SCAN_LSB  = 1;
    localparam int SETUP_CLK_LSB  = 4;
    localparam int SETUP_REF_LSB  = 2;
    localparam int AVG_EN_BIT     = 4;
    localparam int AVG_DEPTH_LSB  = 2;
    localparam int AVG_REP_LSB    = 0;
    localparam int RESET_FIFO_BIT = 3;

    // Clock, reference and scan mode codes
    localparam logic [1:0] CLKM_INT_PIN = 2'h0;
    localparam logic [1:0] CLKM_EXT_ACQ = 2'h1;
    localparam logic [1:0] CLKM_INT_CMD = 2'h2;
    localparam logic [1:0] CLKM_SCLK    = 2'h3;
    localparam logic [1:0] REF_INT_AUTO = 2'h0;
    localparam logic [1:0] REF_EXT      = 2'h1;
    localparam logic [1:0] REF_INT_ON   = 2'h2;
    localparam logic [1:0] REF_RESERVED = 2'h3;
    localparam logic [1:0] SCAN_UP_TO_N = 2'h0;
    localparam logic [1:0] SCAN_N_UP    = 2'h1;
    localparam logic [1:0] SCAN_REPEAT  = 2'h2;
    localparam logic [1:0] SCAN_SINGLE  = 2'h3;

    // Channels, FIFO address width, reset values
    localparam logic [3:0] CH_TOP      = 4'hF;
    localparam logic [3:0] CH_TOP_PIN  = 4'hE;
    localparam logic [1:0] CLK_MODE_RST = 2'h2;
    localparam int FIFO_AW = 4;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } ascs_spi_in_t;

    typedef struct packed {
        logic       power;
        logic       ref_power;
        logic [3:0] channel;
        logic       sample_req;
    } ascs_ana_out_t;

    typedef struct packed {
        logic       sample_valid;
        logic [9:0] sample_data;
    } ascs_ana_in_t;

    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_WAKE  = 5'b00010,
        S_ACQ   = 5'b00100,
        S_CONV  = 5'b01000,
        S_TRACK = 5'b10000
    } ascs_seq_t;

    // Bit 0 first stage, bit 1 second stage, bit 2 previous value
    typedef struct packed {
        logic [2:0] sclk;
        logic [2:0] cs_n;
        logic [2:0] din;
        logic [2:0] cnv;
    } ascs_sync_t;

    typedef struct packed {
        logic [1:0] clk_mode;
        logic [1:0] ref_mode;
        logic       avg_en;
        logic [1:0] avg_depth;
        logic [1:0] rep_cnt;
        logic [3:0] chan_n;
        logic [1:0] scan_mode;
    } ascs_regs_t;

    typedef struct packed {
        logic [3:0] cur_ch;
        logic [3:0] last_ch;
        logic [3:0] res_left;
        logic [5:0] avg_left;
    } ascs_scan_t;

    typedef struct packed {
        ascs_sync_t               sy;
        ascs_regs_t               rg;
        ascs_seq_t                st;
        ascs_scan_t               sc;
        logic [14:0]              acc;
        logic [TIMER_W-1:0]       timer;
        logic                     scan_busy;
        logic                     eoc_n;
        ascs_ana_out_t            ana;
        logic [15:0][15:0]        mem;
        logic [FIFO_AW:0]         wr;
        logic [FIFO_AW:0]         rd;
        logic [7:0]               in_sr;
        logic [2:0]               in_cnt;
        logic [15:0]              out_sr;
        logic [3:0]               out_cnt;
    } ascs_state_t;

    localparam ascs_state_t ST_RESET = '{
        sy: '{sclk: 3'h0, cs_n: 3'h7, din: 3'h0, cnv: 3'h7},
        rg: '{clk_mode: CLK_MODE_RST, default: '0},
        st: S_IDLE,
        eoc_n: 1'b1,
        default: '0
    };

endpackage

//--- logic/ascs_top.sv
// Command decode, scan sequencing, result FIFO and serial port of the ADC.
// Assumes an analog core on clk that answers sample_req with sample_valid;
// serial pins and convert_start_n are asynchronous and synchronised here.
//
// Function
// [RULE1] Bit7=0, bit6=1: setup byte, clock/ref fields
// [RULE2] Modes 00/01: internal clock, pin starts
// [RULE3] Modes 10/11: internal or serial clock
// [RULE4] Power-up: registers zero, clock mode 10
// [RULE5] Everything shut down until a scan
// [RULE6] Reference codes: auto, external, always on
// [RULE7] Bits 7:5=001: averaging byte fields
// [RULE8] Averaging depth 1, 4, 8, 16, 32
// [RULE9] Repeat scan gives 4, 8, 12, 16 results
// [RULE10] Bits 7:4=0001: reset all or FIFO
// [RULE11] Result word: 4 zeros, 10 bits, 2 zeros
// [RULE12] Sample input on rise, shift on fall
// [RULE13] Start by pin or by conversion byte
// [RULE14] Mode 00 pulse runs a whole scan
// [RULE15] End flag low until CS or start falls
// [RULE16] Host waits for end flag before starting
// [RULE17] Host holds start low for acquisition
// [RULE18] Mode 01: fall tracks, rise converts
// [RULE19] Mode 01: one pulse per conversion averaged
// [RULE20] Mode 10: byte runs scan, flag until CS
// [RULE21] Bit7=1: conversion byte, channel and scan
// [RULE22] Scan modes: 0..N, N..top, repeat, single
// [RULE23] Mode 11 never averages
// [RULE24] Sixteen-entry FIFO, in order, reset clears
// [RULE25] Reference wake wait before auto-ref scans; mode 01 goes straight to tracking with no wait
`timescale 1ns/10ps

module ascs_top #(
    parameter int REF_WAKE_CYCLES = ascs_pkg::REF_WAKE_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire ascs_pkg::ascs_spi_in_t  spi_i,
    input  wire logic                    convert_start_n,
    input  wire ascs_pkg::ascs_ana_in_t  ana_i,
    output logic                         dout,
    output logic                         eoc_n,
    output ascs_pkg::ascs_ana_out_t      ana_o
);
    import ascs_pkg::*;

    // Registered state, its next value and a copy kept across a reset command
    ascs_state_t q;
    ascs_state_t d;
    ascs_state_t keep;
    // Pin edges, command strobe and accumulator helpers
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_low;
    logic        cs_fall;
    logic        cnv_rise;
    logic        cnv_fall;
    logic        cmd_v;
    logic [7:0]  cmd;
    logic [14:0] acc_n;
    logic        last_conv;
    logic        scan_end;

    ////////////////////////////////////////////////////////////////////////
    // Conversions per result
    function automatic logic [5:0] avg_count(ascs_regs_t r);
        if (!r.avg_en || r.clk_mode == CLKM_SCLK)               // RULE23
            return 6'h01;                                       // RULE8
        return 6'(6'h04 << r.avg_depth);                        // RULE8
    endfunction

    // First channel, last channel and repeat count of a new scan
    function automatic ascs_scan_t scan_init(ascs_regs_t r);
        ascs_scan_t s;
        logic [3:0] top;
        top = r.clk_mode[1] ? CH_TOP : CH_TOP_PIN;              // RULE3
        s.avg_left = avg_count(r);
        s.res_left = 4'h0;
        s.cur_ch   = r.chan_n;
        s.last_ch  = r.chan_n;
        unique case (r.scan_mode)                               // RULE22
            SCAN_UP_TO_N: s.cur_ch = 4'h0;
            SCAN_N_UP:    s.last_ch = top;
            SCAN_REPEAT:  s.res_left = {r.rep_cnt, 2'h3};       // RULE9
            SCAN_SINGLE:  s.res_left = 4'h0;
        endcase
        return s;
    endfunction

    // Power up and enter the wake or acquisition phase
    function automatic ascs_state_t start_scan(ascs_state_t s);
        s.sc            = scan_init(s.rg);
        s.acc           = '0;
        s.ana.power     = 1'b1;
        s.ana.ref_power = (s.rg.ref_mode != REF_EXT);
        if (s.rg.ref_mode == REF_INT_AUTO) begin
            s.st    = S_WAKE;                                   // RULE25
            s.timer = TIMER_W'(REF_WAKE_CYCLES - 1);
        end else begin
            s.st    = S_ACQ;
            s.timer = TIMER_W'(ACQ_CYC - 1);
        end
        return s;
    endfunction

    // Averaged value placed in the output word
    function automatic logic [15:0] fmt(logic [14:0] a, ascs_regs_t r);
        logic [14:0] v;
        // Shift is 2 plus depth, reckoned in 3 bits so the two top depths do not wrap
        v = (avg_count(r) == 6'h01) ? a : (a >> (3'(r.avg_depth) + 3'h2)); // RULE8
        return {4'h0, v[9:0], 2'h0};                            // RULE11
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Edges of the synchronised pins
    assign sclk_rise = q.sy.sclk[1] & ~q.sy.sclk[2];
    assign sclk_fall = ~q.sy.sclk[1] & q.sy.sclk[2];
    assign cs_low    = ~q.sy.cs_n[1];
    assign cs_fall   = ~q.sy.cs_n[1] & q.sy.cs_n[2];
    assign cnv_rise  = q.sy.cnv[1] & ~q.sy.cnv[2];
    assign cnv_fall  = ~q.sy.cnv[1] & q.sy.cnv[2];

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        keep      = '0;
        cmd_v     = 1'b0;
        cmd       = 8'h00;
        acc_n     = '0;
        last_conv = 1'b0;
        scan_end  = 1'b0;
        d         = q;
        d.ana.sample_req = 1'b0;

        // Two-stage synchronisers plus previous value
        // Only stage two reads stage one; edges compare stages two and three
        d.sy.sclk = {q.sy.sclk[1:0], spi_i.sclk};
        d.sy.cs_n = {q.sy.cs_n[1:0], spi_i.cs_n};
        d.sy.din  = {q.sy.din[1:0], spi_i.din};
        d.sy.cnv  = {q.sy.cnv[1:0], convert_start_n};

        // Command byte assembly on rising serial clock
        if (!cs_low) begin
            d.in_cnt = 3'h0;
        end else if (sclk_rise) begin
            d.in_sr  = {q.in_sr[6:0], q.sy.din[1]};             // RULE12
            d.in_cnt = q.in_cnt + 3'h1;
            if (q.in_cnt == 3'h7) begin
                cmd_v = 1'b1;
                cmd   = {q.in_sr[6:0], q.sy.din[1]};
            end
        end

        // Result shifting on falling serial clock, one entry per select
        // No reload on the sixteenth fall: the next select would pop again
        // and drop an entry; clocks past 16 shift out zeros
        if (cs_fall) begin
            d.out_cnt = 4'h0;
            if (q.wr != q.rd) begin
                d.out_sr = q.mem[q.rd[FIFO_AW-1:0]];           // RULE24
                d.rd     = q.rd + 5'h01;
            end else begin
                d.out_sr = 16'h0000;
            end
        end else if (cs_low && sclk_fall) begin
            d.out_sr  = {q.out_sr[14:0], 1'b0};                 // RULE12
            d.out_cnt = q.out_cnt + 4'h1;
        end

        // End flag released by chip select, or by the start pin in 00/01
        if (cs_fall || (!q.rg.clk_mode[1] && cnv_fall))
            d.eoc_n = 1'b1;                                     // RULE15

        // Sequencer
        unique case (q.st)
            S_IDLE: begin
                if (q.rg.clk_mode == CLKM_INT_PIN && cnv_rise)
                    d = start_scan(d);                          // RULE14
                if (q.rg.clk_mode == CLKM_EXT_ACQ && cnv_fall) begin
                    if (!q.scan_busy) begin
                        d.sc  = scan_init(q.rg);                // RULE18
                        d.acc = '0;
                    end
                    d.scan_busy     = 1'b1;
                    d.ana.power     = 1'b1;                     // RULE18
                    d.ana.ref_power = (q.rg.ref_mode != REF_EXT);
                    d.st            = S_TRACK;
                end
            end
            S_WAKE: begin
                d.timer = q.timer - 1'b1;
                if (q.timer == '0) begin
                    d.st    = S_ACQ;                            // RULE25
                    d.timer = TIMER_W'(ACQ_CYC - 1);
                end
            end
            S_ACQ: begin
                d.timer = q.timer - 1'b1;
                if (q.timer == '0) begin
                    d.st             = S_CONV;                  // RULE2
                    d.ana.sample_req = 1'b1;
                end
            end
            S_TRACK: begin
                if (cnv_rise) begin
                    d.st             = S_CONV;                  // RULE18
                    d.ana.sample_req = 1'b1;
                end
            end
            S_CONV: begin
                if (ana_i.sample_valid) begin
                    acc_n         = q.acc + {5'h00, ana_i.sample_data};
                    d.acc         = acc_n;
                    d.sc.avg_left = q.sc.avg_left - 6'h01;
                    last_conv     = (q.sc.avg_left == 6'h01);
                    if (last_conv) begin
                        // Push the result unless the FIFO is full
                        if (q.wr != {~q.rd[FIFO_AW], q.rd[FIFO_AW-1:0]}) begin
                            d.mem[q.wr[FIFO_AW-1:0]] = fmt(acc_n, q.rg); // RULE24
                            d.wr = q.wr + 5'h01;
                        end
                        d.acc         = '0;
                        d.sc.avg_left = avg_count(q.rg);        // RULE8
                        scan_end = (q.sc.res_left == 4'h0) && (q.sc.cur_ch == q.sc.last_ch);
                        if (q.sc.res_left != 4'h0)
                            d.sc.res_left = q.sc.res_left - 4'h1; // RULE9
                        else if (!scan_end)
                            d.sc.cur_ch = q.sc.cur_ch + 4'h1;   // RULE19
                    end
                    if (q.rg.clk_mode == CLKM_EXT_ACQ) begin
                        // One conversion per start pulse, then shut down
                        d.st        = S_IDLE;                   // RULE19
                        d.ana.power = 1'b0;
                        d.eoc_n     = 1'b0;                     // RULE18
                        if (scan_end) begin
                            d.scan_busy     = 1'b0;
                            d.ana.ref_power = (q.rg.ref_mode == REF_INT_ON); // RULE6
                        end
                    end else if (scan_end) begin
                        d.st            = S_IDLE;
                        d.ana.power     = 1'b0;                 // RULE20
                        d.ana.ref_power = (q.rg.ref_mode == REF_INT_ON); // RULE6
                        d.eoc_n         = 1'b0;                 // RULE14
                    end else begin
                        d.st    = S_ACQ;
                        d.timer = TIMER_W'(ACQ_CYC - 1);
                    end
                end
            end
        endcase

        // Command decode
        if (cmd_v) begin
            if (cmd[CMD_CONV_BIT]) begin
                d.rg.chan_n    = cmd[CONV_CH_LSB +: 4];         // RULE21
                d.rg.scan_mode = cmd[CONV_SCAN_LSB +: 2];       // RULE21
                if (q.rg.clk_mode[1] && q.st == S_IDLE)
                    d = start_scan(d);                          // RULE13
            end else if (cmd[CMD_SETUP_BIT]) begin
                d.rg.clk_mode = cmd[SETUP_CLK_LSB +: 2];        // RULE1
                // Reserved reference code leaves the field as it was
                if (cmd[SETUP_REF_LSB +: 2] != REF_RESERVED)
                    d.rg.ref_mode = cmd[SETUP_REF_LSB +: 2];    // RULE6
            end else if (cmd[CMD_AVG_BIT]) begin
                d.rg.avg_en    = cmd[AVG_EN_BIT];               // RULE7
                d.rg.avg_depth = cmd[AVG_DEPTH_LSB +: 2];       // RULE7
                d.rg.rep_cnt   = cmd[AVG_REP_LSB +: 2];         // RULE7
            end else if (cmd[CMD_RESET_BIT]) begin
                d.wr = '0;                                      // RULE24
                d.rd = '0;                                      // RULE10
                if (!cmd[RESET_FIFO_BIT]) begin
                    // Defaults everywhere except the pin synchronisers and the serial port itself
                    keep     = d;
                    d        = ST_RESET;                        // RULE10
                    d.sy     = keep.sy;
                    d.in_sr  = keep.in_sr;
                    d.in_cnt = keep.in_cnt;
                    d.out_sr = keep.out_sr;
                    d.out_cnt = keep.out_cnt;
                end
            end
        end

        d.ana.channel = d.sc.cur_ch;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    // Synchronous reset returns every field to its power-up default
    always_ff @(posedge clk) begin
        if (srst)
            q <= ST_RESET;                                      // RULE4 RULE5
        else
            q <= d;
    end

    // Outputs straight from state flops
    // No logic between the flops and the pins
    assign dout  = q.out_sr[15];                                // RULE11
    assign eoc_n = q.eoc_n;
    assign ana_o = q.ana;

endmodule // ascs_top

//--- sim/ascs_top_chk.sv
// Pin-level assertions of the ADC scan sequencer, bound into ascs_top.
// Assumes one clk domain with the synchronous active-high srst.
`timescale 1ns/10ps

module ascs_top_chk
    import ascs_pkg::*;
#(
    parameter int REF_WAKE_CYCLES = ascs_pkg::REF_WAKE_CYC
) (
    input wire logic                   clk,
    input wire logic                   srst,
    input wire ascs_pkg::ascs_spi_in_t spi_i,
    input wire logic                   convert_start_n,
    input wire ascs_pkg::ascs_ana_in_t ana_i,
    input wire logic                   dout,
    input wire logic                   eoc_n,
    input wire ascs_pkg::ascs_ana_out_t ana_o
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    logic pend_q;
    logic pend_d;

    // Request outstanding towards the analog core
    always_comb begin
        pend_d = pend_q;
        if (ana_o.sample_req) pend_d = 1'b1;
        else if (ana_i.sample_valid) pend_d = 1'b0;
    end
    always_ff @(posedge clk) begin
        if (srst) pend_q <= 1'b0;
        else pend_q <= pend_d;
    end

    ////////////////////////////////////////
    // Assertions
    a_reset_quiet: assert property ($fell(srst) |-> eoc_n && !dout && !ana_o.power && !ana_o.ref_power)
        else $error("outputs not quiet after reset");
    a_req_powered: assert property (ana_o.sample_req |-> ana_o.power)
        else $error("conversion asked while powered down");
    a_acq_gap: assert property ($rose(ana_o.power) |-> (!ana_o.sample_req)[*8])
        else $error("conversion asked without acquisition");
    a_done_power_off: assert property ($fell(eoc_n) |-> !ana_o.power)
        else $error("end flag while still powered");
    a_cs_clears_eoc: assert property ($fell(spi_i.cs_n) && !eoc_n |-> ##[1:5] eoc_n)
        else $error("end flag not cleared by select");
    a_eoc_holds: assert property ((spi_i.cs_n && convert_start_n)[*6] ##0 !eoc_n |=> !eoc_n)
        else $error("end flag dropped by itself");
    a_dout_on_fall: assert property ($changed(dout) |-> !spi_i.sclk && !$past(spi_i.sclk, 2))
        else $error("data out moved outside a falling clock");
    a_req_waits: assert property (pend_q && !ana_i.sample_valid |-> !ana_o.sample_req)
        else $error("second request before reply");

    // Main scenarios
    c_scan_done: cover property ($fell(eoc_n));
    c_cnv_clear: cover property ($fell(convert_start_n) && !eoc_n);
    c_slow_reply: cover property (pend_q [*8] ##1 ana_i.sample_valid);
endmodule // ascs_top_chk

bind ascs_top ascs_top_chk #(.REF_WAKE_CYCLES(REF_WAKE_CYCLES)) ascs_top_chk_inst (.clk(clk), .srst(srst),
    .spi_i(spi_i), .convert_start_n(convert_start_n), .ana_i(ana_i), .dout(dout), .eoc_n(eoc_n), .ana_o(ana_o));

//--- sim/ascs_core_model.sv
// Behavioural analog core answering the sequencer's conversion requests.
// Assumes one-cycle requests on clk; slow stretches the reply delay.
`timescale 1ns/10ps

module ascs_core_model
    import ascs_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    slow,
    input  wire ascs_pkg::ascs_ana_out_t ana_o,
    output ascs_pkg::ascs_ana_in_t       ana_i
);
    int         wait_q = -1;
    logic [9:0] val_q  = 10'h000;

    // Reply with a channel-tagged code; data toggles between replies
    always @(posedge clk) begin
        if (srst) begin
            wait_q <= -1;
            ana_i  <= '0;
        end else if (ana_o.sample_req) begin
            wait_q <= slow ? 40 : 2;
            val_q  <= {ana_o.channel, 6'h2A};
            ana_i  <= '{sample_valid: 1'b0, sample_data: ~ana_i.sample_data};
        end else if (wait_q == 0) begin
            wait_q <= -1;
            ana_i  <= '{sample_valid: 1'b1, sample_data: val_q};
        end else begin
            if (wait_q > 0)
                wait_q <= wait_q - 1;
            ana_i  <= '{sample_valid: 1'b0, sample_data: ~ana_i.sample_data};
        end
    end
endmodule // ascs_core_model

//--- sim/ascs_top_bench.sv
// Self-checking bench of the ADC scan sequencer through its serial port.
// Assumes the checker and the analog core model are compiled before it.
`timescale 1ns/10ps

module ascs_top_bench;
    import ascs_pkg::*;
    logic          clk, srst, cnv_n, lclk, slow, dout, eoc_n;
    logic [15:0]   r;
    ascs_spi_in_t  spi;
    ascs_ana_in_t  ai;
    ascs_ana_out_t ao;
    int            error_cnt = 0, n_compared = 0, nreq = 0, cyc = 0, n0;

    ascs_top #(.REF_WAKE_CYCLES(20)) ascs_top_inst (.clk(clk), .srst(srst), .spi_i(spi),
        .convert_start_n(cnv_n), .ana_i(ai), .dout(dout), .eoc_n(eoc_n), .ana_o(ao));
    ascs_core_model ascs_core_model_inst (.clk(clk), .srst(srst), .slow(slow), .ana_o(ao), .ana_i(ai));

    // System clock and free link clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        forever #62.5 lclk = ~lclk;
    end

    // Conversion count and run limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ao.sample_req === 1'b1) nreq <= nreq + 1;
        if (cyc == 90000) begin
            error_cnt++;
            $display("wrong value at %0t: run timed out", $time);
            stop_test;
        end
    end

    ////////////////////////////////////////
    // Tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One framed transfer, host drives on fall and samples on rise
    task automatic frame(input int nb, input logic [15:0] w);
        @(posedge clk) spi.cs_n <= 1'b0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            @(negedge lclk);
            @(posedge clk) begin
                spi.sclk <= 1'b0;
                spi.din  <= w[15];
            end
            w = w << 1;
            @(posedge lclk);
            @(posedge clk) begin
                spi.sclk <= 1'b1;
                r        <= {r[14:0], dout};
            end
        end
        @(negedge lclk);
        @(posedge clk) spi.sclk <= 1'b0;
        repeat (8) @(posedge clk);
        spi.cs_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] b);
        frame(8, {b, 8'h00});
    endtask

    task automatic rd(input logic [15:0] exp);
        frame(16, 16'h0000);
        chk(r, exp, "fifo word");
    endtask

    task automatic wait_eoc;
        int n;
        n = 0;
        while (eoc_n !== 1'b0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        chk({15'h0, eoc_n}, 16'h0, "end flag");
    endtask

    task automatic pulse(input int lo);
        @(posedge clk) cnv_n <= 1'b0;
        repeat (lo) @(posedge clk);
        cnv_n <= 1'b1;
    endtask

    task automatic stop_test;
        $display("errors %0d, compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [15:0] wd(input logic [3:0] ch);
        return {4'h0, ch, 6'h2A, 2'b00};
    endfunction

    ////////////////////////////////////////
    // Scenarios
    initial begin
        srst  = 1'b1;
        spi   = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};
        cnv_n = 1'b1;
        slow  = 1'b0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk({12'h0, dout, eoc_n, ao.power, ao.ref_power}, 16'h0004, "reset pins");
        // Default mode runs a scan from the byte, reference sleeps after
        wr(8'hAE);
        wait_eoc;
        chk({14'h0, ao.power, ao.ref_power}, 16'h0, "power after scan");
        rd(wd(4'h5));
        wr(8'h64);
        wr(8'h90);
        wait_eoc;
        for (int c = 0; c < 3; c++) rd(wd(4'(c)));
        slow <= 1'b1;
        wr(8'hEA);
        wait_eoc;
        for (int c = 13; c < 16; c++) rd(wd(4'(c)));
        rd(16'h0000);
        for (int k = 0; k < 4; k++) begin
            wr(8'h20 | 8'(k));
            wr(8'h9C);
            wait_eoc;
            for (int j = 0; j < 4 * (k + 1); j++) rd(wd(4'h3));
            rd(16'h0000);
        end
        slow <= 1'b0;
        for (int d = 0; d < 5; d++) begin
            n0 = nreq;
            wr(d < 4 ? 8'h30 | 8'(d << 2) : 8'h2C);
            wr(8'hBE);
            wait_eoc;
            chk(16'(nreq - n0), d < 4 ? 16'(4 << d) : 16'h1, "conversions");
            rd(wd(4'h7));
        end
        // Serial-clock mode ignores averaging
        wr(8'h74);
        wr(8'h3C);
        n0 = nreq;
        wr(8'hBE);
        wait_eoc;
        chk(16'(nreq - n0), 16'h1, "conversions");
        rd(wd(4'h7));
        // Reference kept on, then both reset commands
        wr(8'h68);
        wr(8'h2C);
        wr(8'h90);
        wait_eoc;
        chk({15'h0, ao.ref_power}, 16'h1, "reference on");
        wr(8'h18);
        rd(16'h0000);
        wr(8'h44);
        wr(8'h10);
        wr(8'hAE);
        wait_eoc;
        rd(wd(4'h5));
        // Pin-started scan, byte alone does nothing
        wr(8'h44);
        n0 = nreq;
        wr(8'hBE);
        repeat (400) @(posedge clk);
        chk({eoc_n, 15'(nreq - n0)}, 16'h8000, "no byte start");
        pulse(6);
        wait_eoc;
        @(posedge clk) cnv_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk({15'h0, eoc_n}, 16'h1, "start clears flag");
        cnv_n <= 1'b1;
        wait_eoc;
        rd(wd(4'h7));
        rd(wd(4'h7));
        // Start-timed acquisition, averaged over four pulses
        wr(8'h54);
        wr(8'h30);
        n0 = nreq;
        for (int p = 0; p < 4; p++) begin
            pulse(200);
            wait_eoc;
        end
        chk(16'(nreq - n0), 16'h4, "conversions");
        rd(wd(4'h7));
        rd(16'h0000);
        stop_test;
    end
endmodule // ascs_top_bench
